/* File: osw_clock_ctrl.sv */
// System clock oscillation, stop and wait controller with APB registers.
// Assumes oscillator ticks, instruction strobes and pins are pclk-synchronous.
//
// What this block does
// - Main-clock stop bit set in low-speed mode halts main oscillator; clear restarts.
// - Stop instruction holds internal clock high and halts both oscillators.
// - Stop with preset bit 0 loads prescaler 12 with FF, timer 1 with 01.
// - Stop with preset bit 1 leaves both counters; software preloads them.
// - During release prescaler 12 counts oscillator/16 and clocks timer 1.
// - External interrupt restarts oscillators; clock stays high until timer 1 underflow.
// - Wait instruction holds internal clock high, oscillators keep running.
// - Reset or interrupt ends wait at once, no stabilization delay.
// - Auto switch enabled in low speed: SCL/SDA edge starts main, goes middle.
// - Delay select picks 4.5-5.5 or 6.5-7.5 low-speed machine cycles.
// - Writing auto switch start bit in low speed switches to middle speed.
// - High-speed mode clock is main oscillator divided by two.
// - Timer latch value n divides its count source by n+1.
// - Middle speed is main oscillator divided by eight and selected at reset.
// - Low-speed mode clock is sub oscillator divided by two.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "osw_params.svh"

module osw_clock_ctrl (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Oscillator ticks and CPU events
   input  wire logic        main_osc_tick,
   input  wire logic        sub_osc_tick,
   input  wire logic        stop_instruction,
   input  wire logic        wait_instruction,
   input  wire logic        ext_irq,
   // Serial line pins
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   // Clock outputs
   output osw_pkg::osw_osc_type osc_ctl,
   output logic             t1_underflow
);

   osw_pkg::osw_main_type s_r;
   osw_pkg::osw_main_type s_nxt;

   logic       wr;
   logic [5:0] idx;
   logic       hit;
   logic       is_low;
   logic       stop_go;
   logic       preset;
   logic       src_tick;
   logic       pre_tick;
   logic       pre_uflow;
   logic       t1_uflow;
   logic       pre_load;
   logic       t1_load;
   logic [7:0] pre_val;
   logic [7:0] t1_val;
   logic [7:0] pre_cnt;
   logic [7:0] t1_cnt;
   logic [3:0] asw_top;
   logic       pin_edge;

   assign prdata       = s_r.prdata;
   assign pready       = s_r.pready;
   assign pslverr      = s_r.pslverr;
   assign osc_ctl      = s_r.osc;
   assign t1_underflow = s_r.t1_uflow;

   // Address decode
   assign idx = paddr[7:2];
   assign hit = (paddr[1:0] == 2'h0) &&
                (idx == `OSW_IDX_PRE12 || idx == `OSW_IDX_T1 ||
                 idx == `OSW_IDX_MISC || idx == `OSW_IDX_CPUM);
   assign wr  = psel & penable & s_r.pready & pwrite & hit;

   assign is_low  = s_r.cpum[`OSW_CPUM_MODE_HI:`OSW_CPUM_MODE_LO] ==
                    osw_pkg::OSW_LOW;
   assign stop_go = stop_instruction & (s_r.st == osw_pkg::OSW_RUN);
   assign preset  = stop_go & ~s_r.misc[`OSW_MISC_PRESET];

   // Counter loads: stop preset wins over a software write
   assign pre_load = preset | (wr && idx == `OSW_IDX_PRE12);
   assign t1_load  = preset | (wr && idx == `OSW_IDX_T1);
   assign pre_val  = preset ? `OSW_PRE12_STP : pwdata[7:0];
   assign t1_val   = preset ? `OSW_T1_STP : pwdata[7:0];

   // Oscillator divided by 16 feeds prescaler 12, which clocks timer 1
   assign src_tick = (s_r.st != osw_pkg::OSW_STOPS) &&
                     (is_low ? sub_osc_tick : main_osc_tick);
   assign pre_tick = src_tick && (s_r.d16 == `OSW_DIV16_TOP);

   assign asw_top  = s_r.misc[`OSW_MISC_ASW_DLY] ? `OSW_ASW_LONG :
                     `OSW_ASW_SHORT;
   assign pin_edge = (scl_in != s_r.scl_q) || (sda_in != s_r.sda_q);

   osw_reload_counter #(
      .RST_VAL (`OSW_PRE12_STP)
   ) u_pre12 (
      .pclk     (pclk),
      .presetn  (presetn),
      .load     (pre_load),
      .load_val (pre_val),
      .tick     (pre_tick),
      .cnt      (pre_cnt),
      .uflow    (pre_uflow)
   );

   osw_reload_counter #(
      .RST_VAL (`OSW_T1_STP)
   ) u_t1 (
      .pclk     (pclk),
      .presetn  (presetn),
      .load     (t1_load),
      .load_val (t1_val),
      .tick     (pre_uflow),
      .cnt      (t1_cnt),
      .uflow    (t1_uflow)
   );

   always_comb begin
      s_nxt          = s_r;
      s_nxt.t1_uflow = t1_uflow;
      s_nxt.scl_q    = scl_in;
      s_nxt.sda_q    = sda_in;

      // APB: one wait cycle, then answer
      s_nxt.pready  = psel & penable & ~s_r.pready;
      s_nxt.pslverr = 1'b0;
      if (psel && penable && !s_r.pready) begin
         s_nxt.pslverr = ~hit;
         s_nxt.prdata  = 32'h0000_0000;
         if (hit) begin
            case (idx)
               `OSW_IDX_PRE12: s_nxt.prdata[7:0] = pre_cnt;
               `OSW_IDX_T1:    s_nxt.prdata[7:0] = t1_cnt;
               `OSW_IDX_MISC:  s_nxt.prdata[2:0] = s_r.misc;
               `OSW_IDX_CPUM:  s_nxt.prdata[7:0] = s_r.cpum;
               default:        s_nxt.prdata      = 32'h0000_0000;
            endcase
         end
      end

      // Register writes
      if (wr && idx == `OSW_IDX_CPUM) begin
         s_nxt.cpum = pwdata[7:0];
      end
      if (wr && idx == `OSW_IDX_MISC) begin
         s_nxt.misc = pwdata[2:0];
      end

      // Divide-by-16 prescaler source
      if (src_tick) begin
         s_nxt.d16 = s_r.d16 + 4'h1;
      end

      // Automatic switch from low speed to middle speed
      if (s_r.asw_busy) begin
         if (sub_osc_tick) begin
            if (s_r.asw_cnt == asw_top - 4'h1) begin
               s_nxt.cpum[`OSW_CPUM_MODE_HI:`OSW_CPUM_MODE_LO] =
                  osw_pkg::OSW_MID;
               s_nxt.asw_busy = 1'b0;
               s_nxt.asw_cnt  = 4'h0;
            end else begin
               s_nxt.asw_cnt = s_r.asw_cnt + 4'h1;
            end
         end
      end else if (is_low && s_r.st == osw_pkg::OSW_RUN &&
                   ((s_r.misc[`OSW_MISC_ASW_EN] && pin_edge) ||
                    (wr && idx == `OSW_IDX_MISC &&
                     pwdata[`OSW_MISC_ASW_GO]))) begin
         s_nxt.asw_busy              = 1'b1;
         s_nxt.asw_cnt               = 4'h0;
         s_nxt.cpum[`OSW_CPUM_MSTOP] = 1'b0;
      end

      // Oscillation control state machine
      case (s_r.st)
         osw_pkg::OSW_RUN: begin
            if (stop_go) begin
               s_nxt.st = osw_pkg::OSW_STOPS;
            end else if (wait_instruction) begin
               s_nxt.st = osw_pkg::OSW_WAITS;
            end
         end
         osw_pkg::OSW_WAITS: begin
            if (ext_irq) begin
               s_nxt.st = osw_pkg::OSW_RUN;
            end
         end
         osw_pkg::OSW_STOPS: begin
            if (ext_irq) begin
               s_nxt.st = osw_pkg::OSW_RELEASE;
            end
         end
         osw_pkg::OSW_RELEASE: begin
            if (t1_uflow) begin
               s_nxt.st = osw_pkg::OSW_RUN;
            end
         end
         default: begin
            s_nxt.st = osw_pkg::OSW_RUN;
         end
      endcase

      // Oscillator enables
      if (s_nxt.st == osw_pkg::OSW_STOPS) begin
         s_nxt.osc.main_en = 1'b0;
         s_nxt.osc.sub_en  = 1'b0;
      end else begin
         s_nxt.osc.sub_en  = 1'b1;
         s_nxt.osc.main_en = ~(s_nxt.cpum[`OSW_CPUM_MSTOP] &&
            s_nxt.cpum[`OSW_CPUM_MODE_HI:`OSW_CPUM_MODE_LO] ==
            osw_pkg::OSW_LOW);
      end

      // Internal clock divider, held high from the edge that leaves run
      if (s_nxt.st != osw_pkg::OSW_RUN) begin
         s_nxt.osc.phi = 1'b1;
         s_nxt.phcnt   = 2'h0;
      end else begin
         case (s_r.cpum[`OSW_CPUM_MODE_HI:`OSW_CPUM_MODE_LO])
            osw_pkg::OSW_HIGH: begin
               if (main_osc_tick) begin
                  s_nxt.osc.phi = ~s_r.osc.phi;
               end
            end
            osw_pkg::OSW_MID: begin
               if (main_osc_tick) begin
                  if (s_r.phcnt == `OSW_MID_HALF_TOP) begin
                     s_nxt.osc.phi = ~s_r.osc.phi;
                     s_nxt.phcnt   = 2'h0;
                  end else begin
                     s_nxt.phcnt = s_r.phcnt + 2'h1;
                  end
               end
            end
            osw_pkg::OSW_LOW: begin
               if (sub_osc_tick) begin
                  s_nxt.osc.phi = ~s_r.osc.phi;
               end
            end
            default: begin
               s_nxt.osc.phi = s_r.osc.phi;
            end
         endcase
      end
   end

   // Reset selects middle speed, no stabilization wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r          <= '0;
         s_r.st       <= osw_pkg::OSW_RUN;
         s_r.cpum     <= `OSW_CPUM_RST;
         s_r.misc     <= `OSW_MISC_RST;
         s_r.osc      <= 3'b111;
      end else begin
         s_r <= s_nxt;
      end
   end

   a_stop_halts_osc: assert property (@(posedge pclk)
      disable iff (!presetn)
      (s_r.st == osw_pkg::OSW_STOPS) |-> (!s_r.osc.main_en &&
         !s_r.osc.sub_en && s_r.osc.phi))
      else $error("stop state leaves an oscillator or clock running");

   a_stop_presets: assert property (@(posedge pclk)
      disable iff (!presetn)
      (stop_go && !s_r.misc[`OSW_MISC_PRESET]) |=>
         (pre_cnt == `OSW_PRE12_STP && t1_cnt == `OSW_T1_STP))
      else $error("stop did not preset prescaler 12 and timer 1");

   a_stop_keeps: assert property (@(posedge pclk)
      disable iff (!presetn)
      (stop_go && s_r.misc[`OSW_MISC_PRESET] && !wr) |=>
         (pre_cnt == $past(pre_cnt) && t1_cnt == $past(t1_cnt)))
      else $error("stop changed counters with preset bit set");

   a_release_held: assert property (@(posedge pclk)
      disable iff (!presetn)
      (s_r.st == osw_pkg::OSW_RELEASE && !t1_uflow) |=>
         (s_r.st == osw_pkg::OSW_RELEASE && s_r.osc.phi &&
          s_r.osc.sub_en))
      else $error("clock delivered before timer 1 underflow");

   a_release_end: assert property (@(posedge pclk)
      disable iff (!presetn)
      (s_r.st == osw_pkg::OSW_RELEASE && t1_uflow) |=>
         (s_r.st == osw_pkg::OSW_RUN && s_r.t1_uflow))
      else $error("timer 1 underflow did not end the release");

   a_wait_osc_run: assert property (@(posedge pclk)
      disable iff (!presetn)
      (s_r.st == osw_pkg::OSW_WAITS && !wr) |=>
         (s_r.osc.phi && s_r.osc.sub_en && $stable(s_r.osc.main_en)))
      else $error("wait state stopped an oscillator");

   a_wait_wake: assert property (@(posedge pclk)
      disable iff (!presetn)
      (s_r.st == osw_pkg::OSW_WAITS && ext_irq) |=>
         (s_r.st == osw_pkg::OSW_RUN))
      else $error("interrupt did not end wait state at once");

   a_main_halt: assert property (@(posedge pclk)
      disable iff (!presetn)
      (is_low && s_r.cpum[`OSW_CPUM_MSTOP]) |-> !s_r.osc.main_en)
      else $error("main oscillator runs with stop bit in low speed");

   a_asw_start: assert property (@(posedge pclk)
      disable iff (!presetn)
      (is_low && s_r.st == osw_pkg::OSW_RUN && !s_r.asw_busy &&
       s_r.misc[`OSW_MISC_ASW_EN] && pin_edge) |=>
         (s_r.asw_busy && s_r.osc.main_en))
      else $error("serial line edge did not start the auto switch");

   a_asw_done: assert property (@(posedge pclk)
      disable iff (!presetn)
      (s_r.asw_busy && sub_osc_tick && s_r.asw_cnt == asw_top - 4'h1)
         |=> (!s_r.asw_busy && s_r.cpum[`OSW_CPUM_MODE_HI:
              `OSW_CPUM_MODE_LO] == osw_pkg::OSW_MID))
      else $error("auto switch did not reach middle speed on time");

   a_high_div: assert property (@(posedge pclk)
      disable iff (!presetn)
      (s_r.st == osw_pkg::OSW_RUN && main_osc_tick &&
       s_r.cpum[`OSW_CPUM_MODE_HI:`OSW_CPUM_MODE_LO] ==
       osw_pkg::OSW_HIGH) |=> (s_r.osc.phi != $past(s_r.osc.phi)))
      else $error("high speed clock did not toggle on main tick");

endmodule // osw_clock_ctrl

`default_nettype wire

/* File: osw_params.svh */
// Constants of the oscillation, stop and wait clock controller.
// Assumes inclusion by bare name from the package and design files.
`ifndef OSW_PARAMS_SVH
`define OSW_PARAMS_SVH

// Register indices; byte address is four times the index
`define OSW_IDX_PRE12      6'h20
`define OSW_IDX_T1         6'h21
`define OSW_IDX_MISC       6'h38
`define OSW_IDX_CPUM       6'h3B

// CPU mode register fields and reset value
`define OSW_CPUM_MSTOP     5
`define OSW_CPUM_MODE_LO   6
`define OSW_CPUM_MODE_HI   7
`define OSW_CPUM_RST       8'h48

// Misc clock settings register fields and reset value
`define OSW_MISC_PRESET    0
`define OSW_MISC_ASW_EN    1
`define OSW_MISC_ASW_DLY   2
`define OSW_MISC_ASW_GO    3
`define OSW_MISC_RST       3'h0

// Counter presets at reset and on the stop instruction
`define OSW_PRE12_STP      8'hFF
`define OSW_T1_STP         8'h01

// Divider and delay counts
`define OSW_DIV16_TOP      4'hF
`define OSW_MID_HALF_TOP   2'h3
`define OSW_ASW_SHORT      4'hA
`define OSW_ASW_LONG       4'hE

`endif

/* File: osw_pkg.sv */
// Types of the oscillation, stop and wait clock controller.
// Assumes osw_params.svh is on the include path.
`include "osw_params.svh"

package osw_pkg;

   typedef enum logic [3:0] {
      OSW_RUN     = 4'b0001,
      OSW_WAITS   = 4'b0010,
      OSW_STOPS   = 4'b0100,
      OSW_RELEASE = 4'b1000
   } osw_state_type;

   typedef enum logic [1:0] {
      OSW_HIGH = 2'b00,
      OSW_MID  = 2'b01,
      OSW_LOW  = 2'b10
   } osw_speed_type;

   typedef struct packed {
      logic       main_en;
      logic       sub_en;
      logic       phi;
   } osw_osc_type;

   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] latch;
   } osw_cnt_type;

   typedef struct packed {
      osw_state_type st;
      logic [7:0]    cpum;
      logic [2:0]    misc;
      logic          pready;
      logic          pslverr;
      logic [31:0]   prdata;
      osw_osc_type   osc;
      logic [1:0]    phcnt;
      logic [3:0]    d16;
      logic          scl_q;
      logic          sda_q;
      logic          asw_busy;
      logic [3:0]    asw_cnt;
      logic          t1_uflow;
   } osw_main_type;

endpackage

/* File: osw_reload_counter.sv */
// Eight-bit down counter with reload latch, divides its ticks by n+1.
// Assumes tick and load are single-cycle strobes on pclk.
`timescale 1ns/10ps
`default_nettype none

module osw_reload_counter #(
   parameter logic [7:0] RST_VAL = 8'h00
) (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Control
   input  wire logic       load,
   input  wire logic [7:0] load_val,
   input  wire logic       tick,
   // Status
   output logic [7:0]      cnt,
   output logic            uflow
);

   osw_pkg::osw_cnt_type s_r;
   osw_pkg::osw_cnt_type s_nxt;

   assign cnt   = s_r.cnt;
   assign uflow = tick & ~load & (s_r.cnt == 8'h00);

   always_comb begin
      s_nxt = s_r;
      if (load) begin
         s_nxt.cnt   = load_val;
         s_nxt.latch = load_val;
      end else if (tick) begin
         if (s_r.cnt == 8'h00) begin
            s_nxt.cnt = s_r.latch;
         end else begin
            s_nxt.cnt = s_r.cnt - 8'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= {RST_VAL, RST_VAL};
      end else begin
         s_r <= s_nxt;
      end
   end

   a_reload_div: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && !load && s_r.cnt == 8'h00) |=> (s_r.cnt == $past(s_r.latch)))
      else $error("counter did not reload from latch on underflow");

endmodule // osw_reload_counter

`default_nettype wire

/* File: osw_osc_partner.sv */
// Resonators and external interrupt source facing the clock controller.
// Assumes osc_ctl enables come from the controller, wake_req from the bench.
`timescale 1ns/10ps
`default_nettype none

module osw_osc_partner (
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // Controller side
   input  wire osw_pkg::osw_osc_type osc_ctl,
   input  wire logic                 wake_req,
   output logic                      main_osc_tick,
   output logic                      sub_osc_tick,
   output logic                      ext_irq
);
   logic [2:0] sub_cnt_r;

   // Main period two pclk, sub period six; a halted oscillator gives no tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sub_cnt_r     <= 3'h0;
         main_osc_tick <= 1'b0;
         sub_osc_tick  <= 1'b0;
         ext_irq       <= 1'b0;
      end else begin
         sub_cnt_r     <= (sub_cnt_r == 3'h5) ? 3'h0 : sub_cnt_r + 3'h1;
         main_osc_tick <= osc_ctl.main_en & ~main_osc_tick;
         sub_osc_tick  <= osc_ctl.sub_en & (sub_cnt_r == 3'h5);
         ext_irq       <= wake_req;
      end
   end
endmodule // osw_osc_partner

`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench: registers, clock modes, auto switch, wait, stop.
// Assumes osw_osc_partner supplies oscillator ticks and the wake interrupt.
`timescale 1ns/10ps
`default_nettype none
`include "osw_params.svh"

module tb_top;
   localparam logic [7:0] A_PRE  = {`OSW_IDX_PRE12, 2'b00};
   localparam logic [7:0] A_T1   = {`OSW_IDX_T1, 2'b00};
   localparam logic [7:0] A_MISC = {`OSW_IDX_MISC, 2'b00};
   localparam logic [7:0] A_CPUM = {`OSW_IDX_CPUM, 2'b00};
   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, err, wake_req, scl_in, sda_in;
   logic        main_osc_tick, sub_osc_tick, ext_irq, t1_underflow;
   logic        stop_instruction, wait_instruction;
   osw_pkg::osw_osc_type osc_ctl;
   int          bad_count, comparisons, cyc, n, t0, k, i;
   logic [7:0]  as_misc [3] = '{8'h02, 8'h06, 8'h08};
   int          as_pin [3]  = '{1, 2, 0};
   int          as_tick [3] = '{`OSW_ASW_SHORT, `OSW_ASW_LONG, `OSW_ASW_SHORT};

   osw_clock_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .main_osc_tick(main_osc_tick), .sub_osc_tick(sub_osc_tick),
      .stop_instruction(stop_instruction), .ext_irq(ext_irq),
      .wait_instruction(wait_instruction), .scl_in(scl_in),
      .sda_in(sda_in), .osc_ctl(osc_ctl), .t1_underflow(t1_underflow));
   osw_osc_partner partner (.pclk(pclk), .presetn(presetn),
      .osc_ctl(osc_ctl), .wake_req(wake_req), .ext_irq(ext_irq),
      .main_osc_tick(main_osc_tick), .sub_osc_tick(sub_osc_tick));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) cyc <= cyc + 1;

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rng(input string nm, input int lo, input int hi, input int g);
      comparisons++;
      if (g < lo || g > hi) begin
         bad_count++;
         $display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int j;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      j = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && j < 20) begin
         @(posedge pclk);
         j++;
      end
      if (j == 20) chk("apb ready", 32'h1, 32'h0);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask

   task automatic pulse(input logic is_stop);
      @(posedge pclk);
      stop_instruction <= is_stop;
      wait_instruction <= ~is_stop;
      @(posedge pclk);
      stop_instruction <= 1'b0;
      wait_instruction <= 1'b0;
      @(negedge pclk);
      if (is_stop) chk("osc after stop", 32'h1, {29'h0, osc_ctl});
   endtask

   task automatic wake();
      @(posedge pclk);
      wake_req <= 1'b1;
      @(posedge pclk);
      wake_req <= 1'b0;
   endtask

   task automatic measure(input logic use_sub, output int cnt);
      logic last, go;
      last = osc_ctl.phi;
      go = 1'b0;
      cnt = 0;
      for (int j = 0; j < 200; j++) begin
         @(negedge pclk);
         if (osc_ctl.phi !== last) begin
            if (go) break;
            go = 1'b1;
            last = osc_ctl.phi;
         end
         if (go && (use_sub ? sub_osc_tick : main_osc_tick) === 1'b1) cnt++;
      end
   endtask

   task automatic resumes(input string nm);
      logic last;
      int j;
      last = osc_ctl.phi;
      for (j = 0; j < 16 && osc_ctl.phi === last; j++) @(negedge pclk);
      chk(nm, 32'h1, {31'h0, j < 16});
   endtask

   task automatic wake_count(input int lo, input int hi);
      int j, ticks;
      logic held;
      ticks = 0;
      held = 1'b1;
      wake();
      for (j = 0; j < 20000 && t1_underflow !== 1'b1; j++) begin
         @(negedge pclk);
         if (main_osc_tick === 1'b1) ticks++;
         if (osc_ctl.phi !== 1'b1 && t1_underflow !== 1'b1) held = 1'b0;
      end
      chk("phi held in release", 32'h1, {31'h0, held});
      rng("release ticks", lo, hi, ticks);
      chk("main after release", 32'h1, {31'h0, osc_ctl.main_en});
      resumes("phi after release");
   endtask

   task automatic conclude();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #1_000_000;
      bad_count++;
      $display("FAIL watchdog expected done seen timeout");
      conclude();
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {stop_instruction, wait_instruction, wake_req} = '0;
      {scl_in, sda_in} = 2'b11;
      {bad_count, comparisons, cyc} = '0;
      repeat (6) @(posedge pclk);
      chk("osc at reset", 32'h7, {29'h0, osc_ctl});
      presetn <= 1'b1;
      rdc("pre12 reset", A_PRE, 32'hFF);
      rdc("t1 reset", A_T1, 32'h01);
      rdc("cpum reset", A_CPUM, 32'h48);
      rdc("misc reset", A_MISC, 32'h0);
      apb(1'b0, 8'h04, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      $display("Test registers done");
      measure(1'b0, n);
      rng("middle ticks per phase", 4, 4, n);
      apb(1'b1, A_CPUM, 32'h08);
      measure(1'b0, n);
      rng("high ticks per phase", 1, 1, n);
      apb(1'b1, A_CPUM, 32'h88);
      measure(1'b1, n);
      rng("low ticks per phase", 1, 1, n);
      apb(1'b1, A_CPUM, 32'hA8);
      repeat (3) @(negedge pclk);
      chk("main halted", 32'h0, {31'h0, osc_ctl.main_en});
      apb(1'b1, A_CPUM, 32'h88);
      repeat (3) @(negedge pclk);
      chk("main restarted", 32'h1, {31'h0, osc_ctl.main_en});
      repeat (20) @(posedge pclk);
      $display("Test modes done");
      for (k = 0; k < 3; k++) begin
         apb(1'b1, A_MISC, 32'h0);
         apb(1'b1, A_CPUM, 32'hA8);
         apb(1'b1, A_MISC, {24'h0, as_misc[k]});
         if (as_pin[k] == 1) scl_in <= ~scl_in;
         if (as_pin[k] == 2) sda_in <= ~sda_in;
         t0 = cyc;
         repeat (3) @(negedge pclk);
         chk("auto main start", 32'h1, {31'h0, osc_ctl.main_en});
         rd = 32'h0;
         for (n = 0; n < 60 && rd[7:6] !== 2'b01; n++) apb(1'b0, A_CPUM, 32'h0);
         rng("switch delay", as_tick[k] * 6 - 8, as_tick[k] * 6 + 8, cyc - t0);
         chk("cpum after switch", 32'h48, rd);
         rdc("misc readback", A_MISC, {29'h0, as_misc[k][2:0]});
      end
      $display("Test auto switch done");
      pulse(1'b0);
      for (i = 0; i < 20; i++) begin
         @(negedge pclk);
         chk("wait hold", 32'h7, {29'h0, osc_ctl});
      end
      wake();
      resumes("phi after wait interrupt");
      pulse(1'b0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      resumes("phi after wait reset");
      $display("Test wait done");
      // Only the external source wakes; no conversion runs
      apb(1'b1, A_MISC, 32'h0);
      pulse(1'b1);
      rdc("pre12 stop preset", A_PRE, 32'hFF);
      rdc("t1 stop preset", A_T1, 32'h01);
      wake_count(8176, 8193);
      apb(1'b1, A_MISC, 32'h01);
      apb(1'b1, A_PRE, 32'h10);
      apb(1'b1, A_T1, 32'h05);
      pulse(1'b1);
      apb(1'b0, A_PRE, 32'h0);
      rng("pre12 kept", 15, 16, rd);
      rdc("t1 kept", A_T1, 32'h05);
      wake_count(1600, 1633);
      $display("Test stop done");
      conclude();
   end
endmodule // tb_top

`default_nettype wire
